// [flash_stretch.sv]
// retriggerable one-shot that stretches an event into a short lamp pulse
`timescale 1ns/10ps
`default_nettype none
module flash_stretch
  import status_led_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic trigger,
  input wire logic [CNT_W-1:0] len,
  output logic lit
);

  logic [CNT_W-1:0] cnt_q;

  assign lit = (cnt_q != '0);

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else if (trigger)
      cnt_q <= (len == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : len;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

endmodule : flash_stretch
`default_nettype wire

// [lamp_observer.sv]
// viewer model: measures lit and dark run lengths of one lamp colour
`timescale 1ns/10ps
`default_nettype none
module lamp_observer
  import status_led_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire lamps_t lamps,
  input wire logic [2:0] sel,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len
);
  logic [15:0] run_q;
  logic last_q;
  logic cur;
  assign cur = lamps[sel];
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_q <= 16'h0001;
      last_q <= 1'b0;
      hi_len <= 16'h0000;
      lo_len <= 16'h0000;
    end
    else if (cur != last_q)
    begin
      if (last_q)
        hi_len <= run_q;
      else
        lo_len <= run_q;
      run_q <= 16'h0001;
      last_q <= cur;
    end
    else
      run_q <= run_q + 16'h0001;
  end
endmodule : lamp_observer
`default_nettype wire

// [phase_gen.sv]
// free-running half-period counter giving an even square phase
`timescale 1ns/10ps
`default_nettype none
module phase_gen
  import status_led_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [CNT_W-1:0] half_cyc,
  output logic phase,
  output logic tick
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] reload;
  logic phase_q;

  assign reload = (half_cyc == '0) ? '0 : half_cyc - 1'b1;
  // >= so that a shortened period takes effect at once
  assign tick = (cnt_q >= reload);
  assign phase = phase_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else if (tick)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      phase_q <= 1'b0;
    else if (tick)
      phase_q <= ~phase_q;
  end

endmodule : phase_gen
`default_nettype wire

// [status_led_pkg.sv]
// constants, types and register map of the status lamp sequencer
package status_led_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_MS = 125;
  localparam int unsigned FLASH_MS = 20;
  localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
  localparam int unsigned FLASH_CYC = FLASH_MS * CYC_PER_MS;

  localparam int CNT_W = 24;
  localparam int NUM_CH = 4;
  localparam logic [2:0] RUN_LAST = 3'h5;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SLOW_OFS = 8'h04;
  localparam logic [7:0] FAST_OFS = 8'h08;
  localparam logic [7:0] FLASH_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;

  localparam int CTRL_OFF_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_MAN_BIT = 2;
  localparam int CTRL_SUP_LSB = 4;
  localparam int CTRL_TRF_LSB = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0777;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    PAT_OFF, PAT_FLASH, PAT_SLOW_BLINK, PAT_FAST_BLINK,
    PAT_ON, PAT_SLOW_WAVER, PAT_FAST_WAVER
  } pattern_t;

  typedef enum logic [2:0] {
    MODE_OFF, MODE_UPDATE, MODE_POWER, MODE_CFGERR,
    MODE_WAIT, MODE_RUN, MODE_MANUAL, MODE_NORMAL
  } mode_t;

  typedef struct packed {
    logic usb_configured;
    logic cfg_error;
    logic low_supply;
    logic fw_update;
    logic [NUM_CH-1:0] frame_evt;
  } status_t;

  typedef struct packed {
    logic supply_green;
    logic supply_yellow;
    logic [NUM_CH-1:0] traffic;
  } lamps_t;

endpackage : status_led_pkg

// [status_led_sequencer.sv]
// status lamp sequencer with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module status_led_sequencer
  import status_led_pkg::*;
#(
  parameter int unsigned SLOW_HALF_DEF = SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF_DEF = FAST_HALF_CYC,
  parameter int unsigned FLASH_DEF = FLASH_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire status_t status,
  output lamps_t lamps
);

  logic addr_ph;
  logic wr_pend_q;
  logic rd_wait_q;
  logic [7:0] acc_addr_q;
  logic acc_hit_q;
  logic [31:0] hrdata_q;
  logic [31:0] ctrl_q;
  logic [CNT_W-1:0] slow_q;
  logic [CNT_W-1:0] fast_q;
  logic [CNT_W-1:0] flash_q;
  logic [CNT_W-1:0] fast_eff;
  logic slow_ph;
  logic fast_ph;
  logic slow_tick;
  logic beat_lit;
  logic [NUM_CH-1:0] flash_lit;
  mode_t mode_d;
  mode_t mode_q;
  logic [2:0] run_q;
  lamps_t lamps_d;
  lamps_t lamps_q;
  pattern_t sup_pat;
  pattern_t trf_pat;
  logic sup_yellow_only;
  logic [1:0] sup_bits;
  logic [1:0] trf_bits;

  // ---- AHB-Lite slave: writes land in the data phase, reads wait once
  assign addr_ph = hsel && htrans[1] && hready;
  assign hreadyout = ~rd_wait_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= addr_ph && hwrite;
      rd_wait_q <= addr_ph && !hwrite;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_addr_q <= 8'h00;
      acc_hit_q <= 1'b0;
    end
    else if (addr_ph)
    begin
      acc_addr_q <= haddr[7:0];
      acc_hit_q <= (haddr[31:8] == 24'h000000);
    end
  end

  function automatic logic wr_to(logic [7:0] ofs);
    wr_to = wr_pend_q && acc_hit_q && (acc_addr_q == ofs);
  endfunction : wr_to

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_q <= CTRL_RST;
    else if (wr_to(CTRL_OFS))
      ctrl_q <= hwdata & CTRL_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      slow_q <= CNT_W'(SLOW_HALF_DEF);
      fast_q <= CNT_W'(FAST_HALF_DEF);
      flash_q <= CNT_W'(FLASH_DEF);
    end
    else
    begin
      if (wr_to(SLOW_OFS))
        slow_q <= hwdata[CNT_W-1:0];
      if (wr_to(FAST_OFS))
        fast_q <= hwdata[CNT_W-1:0];
      if (wr_to(FLASH_OFS))
        flash_q <= hwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      hrdata_q <= 32'h0000_0000;
    else if (rd_wait_q)
    begin
      if (!acc_hit_q)
        hrdata_q <= 32'h0000_0000;
      else
        unique case (acc_addr_q)
          CTRL_OFS: hrdata_q <= ctrl_q;
          SLOW_OFS: hrdata_q <= {8'h00, slow_q};
          FAST_OFS: hrdata_q <= {8'h00, fast_q};
          FLASH_OFS: hrdata_q <= {8'h00, flash_q};
          STAT_OFS: hrdata_q <= {14'h0000, lamps_q, 1'b0, mode_q,
                                 4'h0, status.usb_configured,
                                 status.cfg_error, status.low_supply,
                                 status.fw_update};
          default: hrdata_q <= 32'h0000_0000;
        endcase
    end
  end

  // ---- pattern timebase
  // a bad fast setting falls back to half the slow period
  assign fast_eff = (fast_q < slow_q) ? fast_q : (slow_q >> 1);

  phase_gen u_slow (
    .clk(clk),
    .rst(rst),
    .half_cyc(slow_q),
    .phase(slow_ph),
    .tick(slow_tick)
  );

  phase_gen u_fast (
    .clk(clk),
    .rst(rst),
    .half_cyc(fast_eff),
    .phase(fast_ph),
    .tick()
  );

  // one brief pulse per slow half period (each slow_tick) for the flash pattern
  flash_stretch u_beat (
    .clk(clk),
    .rst(rst),
    .trigger(slow_tick),
    .len(flash_q),
    .lit(beat_lit)
  );

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    flash_stretch u_flash (
      .clk(clk),
      .rst(rst),
      .trigger(status.frame_evt[ch]),
      .len(flash_q),
      .lit(flash_lit[ch])
    );
  end

  // ---- display mode selection
  always_comb
  begin
    if (ctrl_q[CTRL_OFF_BIT])
      mode_d = MODE_OFF;
    else if (status.fw_update)
      mode_d = MODE_UPDATE;
    else if (status.low_supply)
      mode_d = MODE_POWER;
    else if (status.cfg_error)
      mode_d = MODE_CFGERR;
    else if (!status.usb_configured)
      mode_d = MODE_WAIT;
    else if (ctrl_q[CTRL_RUN_BIT])
      mode_d = MODE_RUN;
    else if (ctrl_q[CTRL_MAN_BIT])
      mode_d = MODE_MANUAL;
    else
      mode_d = MODE_NORMAL;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mode_q <= MODE_WAIT;
    else
      mode_q <= mode_d;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      run_q <= 3'h0;
    else if (mode_q != MODE_RUN)
      run_q <= 3'h0;
    else if (slow_tick)
      run_q <= (run_q == RUN_LAST) ? 3'h0 : run_q + 3'h1;
  end

  // ---- lamp drive; result bit 1 is first colour, bit 0 second
  function automatic logic [1:0] pattern_out(pattern_t pat);
    unique case (pat)
      PAT_OFF: pattern_out = 2'h0;
      PAT_FLASH: pattern_out = {beat_lit, 1'b0};
      PAT_SLOW_BLINK: pattern_out = {slow_ph, 1'b0};
      PAT_FAST_BLINK: pattern_out = {fast_ph, 1'b0};
      PAT_ON: pattern_out = 2'h2;
      PAT_SLOW_WAVER: pattern_out = {slow_ph, ~slow_ph};
      PAT_FAST_WAVER: pattern_out = {fast_ph, ~fast_ph};
      default: pattern_out = 2'h0;
    endcase
  endfunction : pattern_out

  always_comb
  begin
    sup_pat = PAT_OFF;
    trf_pat = PAT_OFF;
    sup_yellow_only = 1'b0;
    unique case (mode_q)
      MODE_OFF: ;
      MODE_UPDATE:
      begin
        sup_pat = PAT_ON;
        trf_pat = PAT_FAST_BLINK;
      end
      MODE_POWER, MODE_CFGERR:
      begin
        sup_pat = PAT_SLOW_WAVER;
        trf_pat = PAT_SLOW_BLINK;
      end
      MODE_WAIT:
      begin
        sup_pat = PAT_SLOW_BLINK;
        sup_yellow_only = 1'b1;
      end
      MODE_RUN: ;
      MODE_MANUAL:
      begin
        sup_pat = pattern_t'(ctrl_q[CTRL_SUP_LSB +: 3]);
        trf_pat = pattern_t'(ctrl_q[CTRL_TRF_LSB +: 3]);
      end
      MODE_NORMAL: sup_pat = PAT_ON;
    endcase
  end

  // the function reads the phases itself, so it is evaluated in a process
  always_comb
  begin
    sup_bits = pattern_out(sup_pat);
    trf_bits = pattern_out(trf_pat);
    lamps_d = '0;
    if (sup_yellow_only)
      lamps_d.supply_yellow = sup_bits[1];
    else
    begin
      lamps_d.supply_green = sup_bits[1];
      lamps_d.supply_yellow = sup_bits[0];
    end
    // traffic lamps are yellow only: waver reduces to blink
    lamps_d.traffic = {NUM_CH{trf_bits[1]}};
    if (mode_q == MODE_NORMAL)
      lamps_d.traffic = flash_lit;
    else if (mode_q == MODE_RUN)
    begin
      if (run_q == 3'h0)
        lamps_d.supply_green = 1'b1;
      else if (run_q == 3'h1)
        lamps_d.supply_yellow = 1'b1;
      else
        lamps_d.traffic = NUM_CH'(4'h1 << (run_q - 3'h2));
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      lamps_q <= '0;
    else
      lamps_q <= lamps_d;
  end

  assign lamps = lamps_q;

  // ---- checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_frame_seen;
    (mode_q == MODE_NORMAL && status.frame_evt[0]) ##1
      (mode_q == MODE_NORMAL);
  endsequence

  chk_off_dark: assert property (
    mode_q == MODE_OFF |=> lamps_q == '0)
    else $error("lamp lit in off mode");
  chk_update_fast: assert property (
    mode_q == MODE_UPDATE |=> lamps_q.traffic == {NUM_CH{$past(fast_ph)}})
    else $error("traffic not fast blinking during update");
  chk_wait_blink: assert property (
    mode_q == MODE_WAIT |=> !lamps_q.supply_green &&
      lamps_q.supply_yellow == $past(slow_ph) && lamps_q.traffic == '0)
    else $error("wrong lamps while awaiting configuration");
  chk_waver_colours: assert property (
    mode_q == MODE_POWER |=>
      lamps_q.supply_green == $past(slow_ph) &&
      lamps_q.supply_yellow != lamps_q.supply_green)
    else $error("supply lamp not wavering");
  chk_normal_green: assert property (
    mode_q == MODE_NORMAL |=> lamps_q.supply_green && !lamps_q.supply_yellow)
    else $error("supply lamp not steady green");
  chk_idle_dark: assert property (
    mode_q == MODE_NORMAL && !flash_lit[0] |=> !lamps_q.traffic[0])
    else $error("idle channel lamp lit");
  chk_frame_flash: assert property (
    s_frame_seen |=> lamps_q.traffic[0])
    else $error("frame gave no flash");
  chk_update_first: assert property (
    status.fw_update && !ctrl_q[CTRL_OFF_BIT] |=> mode_q == MODE_UPDATE)
    else $error("update not given top priority");
  chk_fast_shorter: assert property (
    slow_q > CNT_W'(1) |-> fast_eff < slow_q)
    else $error("fast period not below slow");
  chk_run_onehot: assert property (
    mode_q == MODE_RUN ##1 mode_q == MODE_RUN |-> $onehot(lamps_q))
    else $error("running pattern not one lamp at a time");
  chk_read_wait: assert property (
    addr_ph && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule : status_led_sequencer
`default_nettype wire

// [tb.sv]
// self-checking bench of the status lamp sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import status_led_pkg::*;
  typedef struct {logic [31:0] m; logic [31:0] v;} note_t;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, rd_dp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] obs_sel;
  logic [15:0] hi_len, lo_len;
  logic [3:0] r;
  status_t status;
  lamps_t lamps;
  note_t lamp_q[$];
  note_t rd_q[$];
  note_t nl, nr;
  int n_fail, comparisons;
  int run_order[7] = '{5, 4, 0, 1, 2, 3, 5};
  status_led_sequencer #(.SLOW_HALF_DEF(40), .FAST_HALF_DEF(10),
    .FLASH_DEF(3)) dut (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .status(status),
    .lamps(lamps));
  lamp_observer obs (.clk(clk), .rst(rst), .lamps(lamps),
    .sel(obs_sel), .hi_len(hi_len), .lo_len(lo_len));
  always #50 clk = ~clk;
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  always @(negedge clk)
  begin
    // a note pushed at this very edge is still seen at this edge
    #1;
    if (lamp_q.size() > 0)
    begin
      nl = lamp_q.pop_front();
      check(32'(lamps) & nl.m, nl.v);
    end
  end
  always @(posedge clk)
  begin
    if (rd_dp && hreadyout === 1'b1)
    begin
      nr = rd_q.pop_front();
      check(hrdata & nr.m, nr.v);
      check(32'(hresp), 32'h0);
    end
  end
  task automatic ahb(input logic w, input logic [31:0] a, d, m);
    if (clk !== 1'b1)
      @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    if (!w)
    begin
      rd_q.push_back('{m, d & m});
      rd_dp <= 1'b1;
    end
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask : ahb
  task automatic lamp_chk(input logic [31:0] m, v);
    lamp_q.push_back('{m, v});
  endtask : lamp_chk
  task automatic wt(input int b, input logic v, input int lim);
    int k;
    k = 0;
    // look at the lamps only where they are settled
    if (clk === 1'b1)
      @(negedge clk);
    while (lamps[b] !== v && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    if (lamps[b] !== v)
      check(32'h0, 32'h1);
  endtask : wt
  task automatic meas(input int s, input int hi, lo, cyc);
    obs_sel <= 3'(s);
    repeat (cyc) @(posedge clk);
    check(32'(hi_len), 32'(hi));
    if (lo != 0)
      check(32'(lo_len), 32'(lo));
  endtask : meas
  task automatic pulse(input logic [3:0] p);
    if (clk !== 1'b1)
      @(posedge clk);
    status.frame_evt <= p;
    @(posedge clk);
    status.frame_evt <= 4'h0;
    @(posedge clk);
  endtask : pulse
  task automatic fault_chk;
    wt(5, 1'b1, 100);
    lamp_chk(32'h3F, 32'h2F);
    wt(5, 1'b0, 100);
    lamp_chk(32'h3F, 32'h10);
  endtask : fault_chk
  task automatic give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    clk = 0; rst = 1; hsel = 0; htrans = 0; hwrite = 0; rd_dp = 0;
    haddr = 0; hwdata = 0; status = '0; obs_sel = 0;
    n_fail = 0; comparisons = 0;
    void'($urandom(32'h95E5));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ahb(0, 32'(CTRL_OFS), CTRL_RST, 32'hFFFFFFFF);
    ahb(0, 32'(SLOW_OFS), 32'h28, 32'hFFFFFFFF);
    meas(4, 40, 40, 200);
    lamp_chk(32'h2F, 32'h0);
    $display("test wait done");
    status.cfg_error <= 1'b1;
    fault_chk();
    ahb(0, 32'(STAT_OFS), 32'h0304, 32'h070F);
    status <= '{usb_configured: 1, low_supply: 1, default: 0};
    fault_chk();
    ahb(0, 32'(STAT_OFS), 32'h020A, 32'h070F);
    $display("test faults done");
    status.fw_update <= 1'b1;
    meas(0, 10, 10, 60);
    wt(0, 1'b1, 30);
    lamp_chk(32'h3F, 32'h2F);
    ahb(0, 32'(STAT_OFS), 32'h010B, 32'h070F);
    ahb(1, 32'(FAST_OFS), 32'h32, 0);
    ahb(0, 32'(FAST_OFS), 32'h32, 32'hFFFFFFFF);
    meas(0, 20, 20, 120);
    ahb(1, 32'(FAST_OFS), 32'hA, 0);
    $display("test update done");
    status <= '{usb_configured: 1, default: 0};
    repeat (4) @(posedge clk);
    repeat (8)
    begin
      repeat (13) @(negedge clk);
      lamp_chk(32'h3F, 32'h20);
    end
    r = 4'($urandom_range(0, 3));
    pulse(4'h1 << r);
    meas(r, 3, 0, 20);
    pulse(4'h1 << r);
    pulse(4'h1 << r);
    meas(r, 5, 0, 20);
    repeat (4)
    begin
      r = 4'($urandom);
      pulse(r);
      @(posedge clk);
      @(negedge clk);
      lamp_chk(32'h2F, {26'h0, 2'h2, r});
      repeat (6) @(posedge clk);
    end
    $display("test traffic done");
    ahb(1, 32'(SLOW_OFS), 32'hFF000028, 0);
    ahb(0, 32'(SLOW_OFS), 32'h28, 32'hFFFFFFFF);
    ahb(0, 32'h14, 32'h0, 32'hFFFFFFFF);
    ahb(0, 32'h100, 32'h0, 32'hFFFFFFFF);
    ahb(1, 32'(CTRL_OFS), 32'hFFFFFFFF, 0);
    ahb(0, 32'(CTRL_OFS), CTRL_MASK, 32'hFFFFFFFF);
    repeat (4) @(negedge clk);
    lamp_chk(32'h3F, 32'h0);
    ahb(1, 32'(CTRL_OFS), 32'h2, 0);
    wt(5, 1'b1, 300);
    foreach (run_order[i])
    begin
      wt(run_order[i], 1'b1, 45);
      lamp_chk(32'h3F, 32'h1 << run_order[i]);
    end
    ahb(1, 32'(CTRL_OFS), 32'h464, 0);
    meas(5, 10, 10, 60);
    wt(5, 1'b0, 30);
    lamp_chk(32'h3F, 32'h1F);
    ahb(1, 32'(CTRL_OFS), 32'h314, 0);
    meas(5, 3, 37, 100);
    meas(0, 10, 10, 60);
    $display("test software done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
